// ===== rtl/lait_pkg.sv
// Constants for the light converter integration timing block.
// Assumes an APB master with 32-bit data and byte addresses of 4 x index.
package lait_pkg;
   // ==========================================================
   // Register indices, byte address is four times the index
   localparam logic [3:0] IDX_COMMAND = 4'h0;
   localparam logic [3:0] IDX_CONTROL = 4'h1;
   localparam logic [3:0] IDX_DATA_LO = 4'h4;
   localparam logic [3:0] IDX_DATA_HI = 4'h5;
   localparam logic [3:0] IDX_TIMER_LO = 4'h6;
   localparam logic [3:0] IDX_TIMER_HI = 4'h7;
   localparam logic [3:0] IDX_SYNC = 4'h8;
   localparam logic [3:0] IDX_STATUS = 4'h9;
   localparam int ADDR_LSB = 2;
   localparam int ADDR_W = 8;

   // ==========================================================
   // Command register fields
   localparam int CMD_ENABLE_BIT = 7;
   localparam int CMD_PDOWN_BIT = 6;
   localparam int CMD_MODE_BIT = 5;
   localparam int CMD_SEL_LSB = 2;
   localparam int CMD_WIDTH_LSB = 0;
   localparam logic [1:0] SEL_LIGHT = 2'h2;
   localparam logic [7:0] COMMAND_RESET = 8'h00;

   // ==========================================================
   // Control register fields, range bits 3:2
   localparam int CTRL_RANGE_LSB = 2;
   localparam logic [3:0] CONTROL_MASK = 4'hC;
   localparam logic [7:0] CONTROL_RESET = 8'h00;

   // ==========================================================
   // Status register fields
   localparam int STAT_NEW_BIT = 0;

   // ==========================================================
   // Cycle counts per conversion, by width field
   localparam logic [16:0] CYC_W00 = 17'h1_0000;
   localparam logic [16:0] CYC_W01 = 17'h0_1000;
   localparam logic [16:0] CYC_W10 = 17'h0_0100;
   localparam logic [16:0] CYC_W11 = 17'h0_0010;
   localparam logic [16:0] EXT_CNT_MAX = 17'h0_FFFF;

   typedef enum logic [1:0] {PH_IDLE, PH_ARRAY1, PH_ARRAY2} lait_phase_type;
endpackage

// ===== rtl/lait_integration_timing.sv
// Integration timing sequencer for a charge-balancing light converter.
// Assumes an APB master on clk and a free-running oscillator clock oscClk
// with a modulator bit that is valid in the oscClk domain.
//
// Decided for this implementation: the placing of the registers and the APB slave port.
`timescale 1ns/100ps

module lait_integration_timing (
   input wire logic clk,
   input wire logic rst,
   input wire logic oscClk,
   input wire logic modBit,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr
);
   // ==========================================================
   // Bus side registers
   logic [7:0] command_q;
   logic [3:0] control_q;
   logic [15:0] data_q, timer_q;
   logic [31:0] prdata_q;
   logic syncTog_q, newData_q, pready_q, pslverr_q;
   logic resTogMeta_q, resTogSync_q, resTogSeen_q;

   // ==========================================================
   // Oscillator side registers
   logic [11:0] cfgMeta_q, cfgSync_q;
   logic syncMeta_q, syncSync_q, syncSeen_q;
   logic divTog_q, tick_q, resTog_q;
   lait_pkg::lait_phase_type phase_q;
   localparam lait_pkg::lait_phase_type PH_IDLE = lait_pkg::PH_IDLE;
   localparam lait_pkg::lait_phase_type PH_ARRAY1 = lait_pkg::PH_ARRAY1;
   localparam lait_pkg::lait_phase_type PH_ARRAY2 = lait_pkg::PH_ARRAY2;
   logic [16:0] cnt_q;
   logic signed [17:0] acc_q;
   logic [15:0] resData_q, resTimer_q;

   logic setup, access, mapped, resEdge;
   logic [3:0] idx;

   assign setup = psel && !penable && !pready_q;
   assign access = psel && penable && pready_q;
   assign idx = paddr[lait_pkg::ADDR_LSB+3:lait_pkg::ADDR_LSB];
   assign resEdge = resTogSync_q ^ resTogSeen_q;

   // Decode of the word index; low two address bits must be zero
   always_comb begin
      mapped = 1'b0;
      if (paddr[1:0] == 2'b00 && paddr[7:6] == 2'b00) begin
         mapped = (idx <= lait_pkg::IDX_STATUS) &&
            !(idx == 4'h2 || idx == 4'h3);
      end
   end

   // ==========================================================
   // APB answer: no wait states, data and error prepared at setup
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
      end else begin
         pready_q <= setup;
         pslverr_q <= setup && !mapped;
      end
   end

   // Read mux, registered so prdata comes from a flip-flop
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         prdata_q <= 32'h0000_0000;
      end else if (setup && !pwrite && mapped) begin
         unique case (idx)
            lait_pkg::IDX_COMMAND: prdata_q <= {24'h00_0000, command_q};
            lait_pkg::IDX_CONTROL: prdata_q <= {28'h000_0000, control_q};
            lait_pkg::IDX_DATA_LO: prdata_q <= {24'h00_0000, data_q[7:0]};
            lait_pkg::IDX_DATA_HI: prdata_q <= {24'h00_0000, data_q[15:8]};
            lait_pkg::IDX_TIMER_LO: prdata_q <= {24'h00_0000, timer_q[7:0]};
            lait_pkg::IDX_TIMER_HI: prdata_q <= {24'h00_0000, timer_q[15:8]};
            lait_pkg::IDX_STATUS: prdata_q <= {31'h0000_0000, newData_q};
            default: prdata_q <= 32'h0000_0000;
         endcase
      end else if (setup) begin
         prdata_q <= 32'h0000_0000;
      end
   end

   // Configuration writes take effect at the access edge only
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         command_q <= lait_pkg::COMMAND_RESET;
         control_q <= lait_pkg::CONTROL_RESET[3:0];
      end else if (access && pwrite) begin
         if (idx == lait_pkg::IDX_COMMAND) begin
            command_q <= pwdata[7:0];
         end
         if (idx == lait_pkg::IDX_CONTROL) begin
            control_q <= pwdata[3:0] & lait_pkg::CONTROL_MASK;
         end
      end
   end

   // Sync command: any write to the sync word flips the event toggle
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         syncTog_q <= 1'b0;
      end else if (access && pwrite && idx == lait_pkg::IDX_SYNC) begin
         syncTog_q <= !syncTog_q;
      end
   end

   // ==========================================================
   // Result return: toggle crossing, words are stable when it lands
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         resTogMeta_q <= 1'b0;
         resTogSync_q <= 1'b0;
         resTogSeen_q <= 1'b0;
      end else begin
         resTogMeta_q <= resTog_q;
         resTogSync_q <= resTogMeta_q;
         resTogSeen_q <= resTogSync_q;
      end
   end

   // Data and timer words refreshed on every finished integration
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         data_q <= 16'h0000;
         timer_q <= 16'h0000;
      end else if (resEdge) begin
         data_q <= resData_q;
         timer_q <= resTimer_q;
      end
   end

   // New-data flag: a fresh result wins over a clear in the same cycle
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         newData_q <= 1'b0;
      end else if (resEdge) begin
         newData_q <= 1'b1;
      end else if (access && pwrite && idx == lait_pkg::IDX_STATUS &&
            pwdata[lait_pkg::STAT_NEW_BIT]) begin
         newData_q <= 1'b0;
      end
   end

   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;

   // ==========================================================
   // Oscillator domain: quasi-static configuration, two flops
   // Limitation: software should change these only while disabled
   always_ff @(posedge oscClk or posedge rst) begin
      if (rst) begin
         cfgMeta_q <= 12'h000;
         cfgSync_q <= 12'h000;
      end else begin
         cfgMeta_q <= {control_q, command_q};
         cfgSync_q <= cfgMeta_q;
      end
   end

   // Sync event toggle, edge found on the second and third flops
   always_ff @(posedge oscClk or posedge rst) begin
      if (rst) begin
         syncMeta_q <= 1'b0;
         syncSync_q <= 1'b0;
         syncSeen_q <= 1'b0;
      end else begin
         syncMeta_q <= syncTog_q;
         syncSync_q <= syncMeta_q;
         syncSeen_q <= syncSync_q;
      end
   end

   logic run, extMode, slowRange, syncEdge;
   logic [1:0] width;
   logic [16:0] cycTotal, cntNext;
   logic signed [17:0] accNext;
   logic halfDone, fullDone;
   logic [15:0] clipData;

   assign run = cfgSync_q[lait_pkg::CMD_ENABLE_BIT] &&
      !cfgSync_q[lait_pkg::CMD_PDOWN_BIT] &&
      cfgSync_q[lait_pkg::CMD_SEL_LSB+1:lait_pkg::CMD_SEL_LSB] ==
      lait_pkg::SEL_LIGHT;
   assign extMode = cfgSync_q[lait_pkg::CMD_MODE_BIT];
   assign width = cfgSync_q[lait_pkg::CMD_WIDTH_LSB+1:lait_pkg::CMD_WIDTH_LSB];
   assign slowRange = !cfgSync_q[8+lait_pkg::CTRL_RANGE_LSB+1];
   assign syncEdge = syncSync_q ^ syncSeen_q;

   // Cycles per conversion by width field
   always_comb begin
      unique case (width)
         2'b00: cycTotal = lait_pkg::CYC_W00;
         2'b01: cycTotal = lait_pkg::CYC_W01;
         2'b10: cycTotal = lait_pkg::CYC_W10;
         2'b11: cycTotal = lait_pkg::CYC_W11;
      endcase
   end

   // Oscillator tick: every edge for range 3/4, every other for 1/2
   always_ff @(posedge oscClk or posedge rst) begin
      if (rst) begin
         divTog_q <= 1'b0;
         tick_q <= 1'b0;
      end else begin
         divTog_q <= !divTog_q;
         tick_q <= slowRange ? divTog_q : 1'b1;
      end
   end

   // Next counter and accumulator values for this edge
   always_comb begin
      cntNext = cnt_q;
      accNext = acc_q;
      if (tick_q && phase_q != PH_IDLE) begin
         if (!extMode || cnt_q != lait_pkg::EXT_CNT_MAX) begin
            cntNext = cnt_q + 17'h0_0001;
         end
         if (modBit) begin
            accNext = (phase_q == PH_ARRAY1) ? acc_q + 18'sh0_0001 :
               acc_q - 18'sh0_0001;
         end
      end
   end

   assign halfDone = !extMode && tick_q && phase_q == PH_ARRAY1 &&
      cntNext == {1'b0, cycTotal[16:1]};
   assign fullDone = !extMode && tick_q && phase_q == PH_ARRAY2 &&
      cntNext == cycTotal;

   // Clip the difference to zero and to the full-scale count
   always_comb begin
      clipData = accNext[15:0];
      if (accNext < 18'sh0_0000) begin
         clipData = 16'h0000;
      end else if (!extMode && accNext > $signed({1'b0, cycTotal[16:1]})) begin
         clipData = cycTotal[16:1];
      end else if (extMode && accNext > $signed({1'b0, cntNext})) begin
         clipData = cntNext[15:0];
      end
   end

   logic publish;
   assign publish = run && (fullDone ||
      (extMode && syncEdge && phase_q == PH_ARRAY2));

   // Integration phase sequencer for both timing modes
   always_ff @(posedge oscClk or posedge rst) begin
      if (rst) begin
         phase_q <= PH_IDLE;
      end else if (!run) begin
         phase_q <= PH_IDLE;
      end else if (extMode) begin
         if (syncEdge) begin
            unique case (phase_q)
               PH_IDLE: phase_q <= PH_ARRAY1;
               PH_ARRAY1: phase_q <= PH_ARRAY2;
               PH_ARRAY2: phase_q <= PH_ARRAY1;
            endcase
         end
      end else begin
         unique case (phase_q)
            PH_IDLE: phase_q <= PH_ARRAY1;
            PH_ARRAY1: phase_q <= halfDone ? PH_ARRAY2 : PH_ARRAY1;
            PH_ARRAY2: phase_q <= fullDone ? PH_ARRAY1 : PH_ARRAY2;
         endcase
      end
   end

   // Counter and accumulator, cleared when an integration starts
   always_ff @(posedge oscClk or posedge rst) begin
      if (rst) begin
         cnt_q <= 17'h0_0000;
         acc_q <= 18'sh0_0000;
      end else if (!run || publish ||
            (extMode && syncEdge && phase_q == PH_IDLE)) begin
         cnt_q <= 17'h0_0000;
         acc_q <= 18'sh0_0000;
      end else begin
         cnt_q <= cntNext;
         acc_q <= accNext;
      end
   end

   // Result words held steady until the next publish, toggle flips on the same edge
   always_ff @(posedge oscClk or posedge rst) begin
      if (rst) begin
         resData_q <= 16'h0000;
         resTimer_q <= 16'h0000;
         resTog_q <= 1'b0;
      end else if (publish) begin
         resData_q <= clipData;
         resTimer_q <= cntNext[15:0];
         resTog_q <= !resTog_q;
      end
   end

   // ==========================================================
   // Checks
   sequence s_first_sync;
      run && extMode && syncEdge && phase_q == PH_IDLE;
   endsequence
   sequence s_second_sync;
      run && extMode && syncEdge && phase_q == PH_ARRAY1;
   endsequence

   AST_RANGE_DIV: assert property (@(posedge oscClk) disable iff (rst)
      slowRange && $past(slowRange) && tick_q |=> !tick_q)
      else $error("slow range tick not halved");
   AST_INT_END: assert property (@(posedge oscClk) disable iff (rst)
      fullDone && run |=> resTog_q != $past(resTog_q) && cnt_q == 17'h0_0000)
      else $error("internal integration end missed");
   AST_MODE_BIT: assert property (@(posedge clk) disable iff (rst)
      access && pwrite && idx == lait_pkg::IDX_COMMAND |=>
      command_q[lait_pkg::CMD_MODE_BIT] == $past(pwdata[5]))
      else $error("mode bit not stored");
   AST_SYNC1: assert property (@(posedge oscClk) disable iff (rst)
      s_first_sync |=> phase_q == PH_ARRAY1 && cnt_q == 17'h0_0000)
      else $error("first sync did not start array one");
   AST_SYNC2: assert property (@(posedge oscClk) disable iff (rst)
      s_second_sync |=> phase_q == PH_ARRAY2 && resTog_q == $past(resTog_q))
      else $error("second sync did not switch arrays");
   AST_SYNC3: assert property (@(posedge oscClk) disable iff (rst)
      run && extMode && syncEdge && phase_q == PH_ARRAY2 |=>
      phase_q == PH_ARRAY1 && resTog_q != $past(resTog_q))
      else $error("third sync did not publish");
   AST_CNT_SAT: assert property (@(posedge oscClk) disable iff (rst)
      extMode && $past(extMode) && cnt_q == lait_pkg::EXT_CNT_MAX && tick_q
      && !publish && !syncEdge && run |=> cnt_q == lait_pkg::EXT_CNT_MAX)
      else $error("external counter passed its limit");
   AST_TIMER_LATCH: assert property (@(posedge oscClk) disable iff (rst)
      publish |=> resTimer_q == $past(cntNext[15:0]))
      else $error("timer value not latched");
   AST_DATA_CAP: assert property (@(posedge clk) disable iff (rst)
      resEdge |=> data_q == $past(resData_q) && newData_q ##1
      (newData_q || $past(access && idx == lait_pkg::IDX_STATUS)))
      else $error("data word not refreshed");
   AST_FULL_SCALE: assert property (@(posedge oscClk) disable iff (rst)
      publish && !extMode |=> resData_q <= $past(cycTotal[16:1]))
      else $error("internal count above full scale");
endmodule

// ===== sim/lait_osc_model.sv
// Model of the conversion oscillator and modulator feeding the block.
// Assumes the bench only reads the two outputs; it never resets this.
`timescale 1ns/100ps
module lait_osc_model (
   output logic oscClk,
   output logic modBit
);
   logic [3:0] pat_q = 4'h1;

   // =====
   // Oscillator
   // Free running, 48 ns, started off the bus clock's phase
   initial begin
      oscClk = 1'b0;
      #7.3;
      forever #24 oscClk = ~oscClk;
   end

   // Modulator pattern, changes each cycle so a stuck sample shows
   always @(posedge oscClk) begin
      pat_q <= {pat_q[2:0], pat_q[3] ^ pat_q[2]};
   end
   assign modBit = pat_q[3];
endmodule

// ===== sim/lait_testbench.sv
// Self-checking bench for the integration timing block over APB.
// Assumes the oscillator model runs free and the design answers in 2 cycles.
`timescale 1ns/100ps
module testbench;
   logic clk;
   logic rst;
   logic oscClk;
   logic modBit;
   logic psel;
   logic penable;
   logic pwrite;
   logic [7:0] paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic [31:0] rd;
   logic [31:0] tval;
   logic err;
   int errors = 0;
   int nCompared = 0;
   int cycles = 0;

   lait_integration_timing lait_integration_timing_inst (
      .clk(clk), .rst(rst), .oscClk(oscClk), .modBit(modBit),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr)
   );
   lait_osc_model lait_osc_model_inst (.oscClk(oscClk), .modBit(modBit));

   // =====
   // Clock and timeout
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   // Longest test is near 8k cycles; a whole run reaching 60000 means a hang
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 60000) begin
         errors++;
         finish_test();
      end
   end

   // =====
   // Checking and closing
   task automatic finish_test();
      if (errors == 0 && nCompared > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      nCompared++;
      if (got !== exp) begin
         errors++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   // Unknown compares give X, so the test is against 1'b1 exactly
   task automatic chkIn(input logic [31:0] got, input logic [31:0] lo,
         input logic [31:0] hi);
      nCompared++;
      if ((got >= lo && got <= hi) !== 1'b1) begin
         errors++;
         $display("[ERR] %0t got %h exp %h to %h", $time, got, lo, hi);
      end
   endtask

   // =====
   // APB master, one idle cycle before each setup
   task automatic apb(input logic w, input logic [7:0] a,
         input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      chk(32'(n), 32'h0000_0001);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
      chk(32'(err), 32'h0000_0000);
   endtask
   task automatic rdr(input logic [7:0] a);
      apb(1'b0, a, 32'h0000_0000);
   endtask
   // Byte pair read; stray upper bits land in the result and show up
   task automatic rd16(input logic [7:0] a);
      rdr(a);
      tval = rd;
      rdr(a + 8'h04);
      tval = tval | (rd << 8);
   endtask
   task automatic waitNew();
      int n;
      n = 0;
      do begin
         rdr(8'h24);
         n++;
      end while (rd[0] !== 1'b1 && n < 20000);
      chk(32'(rd[0]), 32'h0000_0001);
      wr(8'h24, 32'h0000_0001);
   endtask
   // Config only changes while disabled
   task automatic cfg(input logic [31:0] ctl, input logic [31:0] cmd);
      wr(8'h00, 32'h0000_0000);
      repeat (12) @(posedge clk); // Let a result in flight land first
      wr(8'h04, ctl);
      wr(8'h24, 32'h0000_0001);
      wr(8'h00, cmd);
   endtask

   // =====
   // Scenario tasks
   task automatic period(input logic [31:0] ctl, input logic [31:0] lo,
         input logic [31:0] hi);
      int t;
      cfg(ctl, 32'h0000_008B);
      waitNew();
      waitNew();
      t = cycles;
      waitNew();
      chkIn(32'(cycles - t), lo, hi);
   endtask
   // Syncs every 200 cycles plus the 3-cycle write: about 105.7 oscClk cycles
   task automatic extRun(input logic [31:0] ctl, input logic [31:0] lo,
         input logic [31:0] hi);
      int t;
      cfg(ctl, 32'h0000_00A8);
      wr(8'h20, 32'h0000_0000);
      for (int k = 0; k < 4; k++) begin
         t = cycles;
         if (k == 2) begin
            waitNew();
            rd16(8'h18);
            chkIn(tval, lo, hi);
            rd16(8'h10);
            chkIn(tval, 32'h0000_0000, hi);
         end else begin
            rdr(8'h24);
            chk(rd, 32'h0000_0000);
         end
         // Equal spacing, far under the counter limit
         while (cycles < t + 200) @(posedge clk);
         wr(8'h20, 32'h0000_0000);
      end
      waitNew();
      rd16(8'h18);
      chkIn(tval, lo, hi);
   endtask

   // =====
   // Main sequence
   initial begin
      rst = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0000_0000;
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      rdr(8'h00);
      chk(rd, 32'h0000_0000);
      rdr(8'h04);
      chk(rd, 32'h0000_0000);
      wr(8'h04, 32'h0000_00FF);
      rdr(8'h04);
      chk(rd, 32'h0000_000C);
      apb(1'b0, 8'h08, 32'h0000_0000);
      chk({rd[30:0], err}, 32'h0000_0001);
      apb(1'b1, 8'h01, 32'h0000_00FF);
      chk(32'(err), 32'h0000_0001);
      // Internal mode, widths 11, 10, 01; 00 is too long to run
      for (int w = 3; w >= 1; w--) begin
         cfg(32'h0000_000C, 32'h0000_0088 + 32'(w));
         waitNew();
         rd16(8'h18);
         chk(tval, 32'h0000_0001 << (16 - 4 * w));
         rd16(8'h10);
         chkIn(tval, 32'h0000_0000, 32'h0000_0001 << (15 - 4 * w));
      end
      period(32'h0000_000C, 32'h0000_0019, 32'h0000_0025);
      period(32'h0000_0000, 32'h0000_0037, 32'h0000_0044);
      extRun(32'h0000_000C, 32'h0000_00CF, 32'h0000_00D8);
      extRun(32'h0000_0004, 32'h0000_0065, 32'h0000_006E);
      finish_test();
   end
endmodule
